// [shared/sdr_cfg.svh]
// constants for the reclocker output control block
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH

// register byte offsets, decoded on the low address bits
`define SDR_DEC_W        8
`define SDR_OFS_CTRL     8'h00
`define SDR_OFS_STATUS   8'h04
`define SDR_OFS_INT_STAT 8'h08
`define SDR_OFS_INT_MASK 8'h0c

// control register fields
`define SDR_CTRL_W       2
`define SDR_CTRL_MUTE    0
`define SDR_CTRL_BYPASS  1
`define SDR_CTRL_RST     2'h0

// interrupt fields
`define SDR_INT_W        3
`define SDR_INT_LOCK_UP  0
`define SDR_INT_LOCK_DN  1
`define SDR_INT_UNSUP    2
`define SDR_INT_RST      3'h0

// status padding above the used bits
`define SDR_STAT_PAD     23

// pin synchroniser: five control pins then four serial inputs
`define SDR_SYNC_N       9
`define SDR_PIN_N        5
`define SDR_SYNC_RST     9'h010

// ahb encodings
`define SDR_HTRANS_NSEQ  2'h2
`define SDR_HSIZE_WORD   3'h2
`define SDR_HRESP_OKAY   1'h0

// static level of a muted pair
`define SDR_MUTE_P       1'h0
`define SDR_MUTE_N       1'h1

`endif

// [shared/sdr_pkg.sv]
// types shared by the reclocker output control block
package sdr_pkg;

    // rate class reported by the clock recovery core
    typedef enum logic [2:0] {
        RATE_NONE     = 3'h0,
        RATE_270      = 3'h1,
        RATE_1483     = 3'h2,
        RATE_1485     = 3'h3,
        RATE_2967     = 3'h4,
        RATE_2970     = 3'h5,
        RATE_UNSUP    = 3'h6,
        RATE_HARMONIC = 3'h7
    } sdr_rate_t;

    // path mode, gray along auto -> retime -> forced
    typedef enum logic [1:0] {
        MODE_AUTO   = 2'h0,
        MODE_RETIME = 2'h1,
        MODE_FORCED = 2'h3
    } sdr_mode_t;

    // cleaned control pins, same layout as the sync vector low bits
    typedef struct packed {
        logic       silenceN;
        logic       bypassForce;
        logic       clockSelect;
        logic [1:0] inputSelect;
    } sdr_pins_t;

    // one differential output pair
    typedef struct packed {
        logic p;
        logic n;
    } sdr_diff_t;

    // only the five video rates may be retimed
    function automatic logic sdr_rate_ok(input sdr_rate_t r);
        return (r == RATE_270) || (r == RATE_1483) || (r == RATE_1485) ||
               (r == RATE_2967) || (r == RATE_2970);
    endfunction

endpackage

// [src/sdr_bit_timer.sv]
// bit interval timer: bit boundary strobe and centred recovered clock
`timescale 1ns/100ps
module sdr_bit_timer #(
    parameter int DIV = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      bitStrobe,
    output logic      midStrobe,
    output logic      recClk
);
    localparam int CW   = (DIV > 2) ? $clog2(DIV) : 1;
    localparam int HALF = DIV / 2;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] MID  = CW'(HALF);

    // the centre needs an even split of the interval
    if (DIV < 2 || (DIV % 2) != 0) begin : g_chk
        $error("sdr_bit_timer: DIV must be even and at least 2");
    end

    logic [CW-1:0] cnt;

    // free running interval counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

    assign bitStrobe = (cnt == '0);
    assign midStrobe = (cnt == MID);

    // clock rises mid bit, falls on the boundary
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            recClk <= 1'h0;
        end else if (midStrobe) begin
            recClk <= 1'h1;
        end else if (bitStrobe) begin
            recClk <= 1'h0;
        end
    end

    property p_clock_centre;
        @(posedge ref_clk) disable iff (!rst_n)
        bitStrobe |-> ##HALF midStrobe;
    endproperty
    a_clock_centre: assert property (p_clock_centre) else $error("clock edge off bit centre");

endmodule

// [src/sdr_output_control.sv]
// reclocker output control: input mux, retime/bypass, output routing, mute, ahb regs
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "sdr_cfg.svh"
module sdr_output_control #(
    parameter int BIT_DIV = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [3:0]        serialInputs,
    input  wire logic              inputSelectBit0,
    input  wire logic              inputSelectBit1,
    input  wire logic              clockOutSelect,
    input  wire logic              outputSilence_n,
    input  wire logic              bypassForce,
    input  wire logic              cdrLocked,
    input  wire logic              signalPresent,
    input  sdr_pkg::sdr_rate_t     detectedRate,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    output sdr_pkg::sdr_diff_t     primarySerialOutput,
    output sdr_pkg::sdr_diff_t     secondarySerialOutput,
    output logic                   lockIndicator,
    output logic                   irq
);

    localparam int N = `SDR_SYNC_N;
    localparam logic [N-1:0] SYNC_RST = `SDR_SYNC_RST;
    localparam sdr_pkg::sdr_diff_t MUTED = '{p: `SDR_MUTE_P, n: `SDR_MUTE_N};

    // the sync vector is sized for exactly four serial inputs
    if (N != `SDR_PIN_N + 4) begin : g_chk
        $error("sdr_output_control: sync vector does not match pin count");
    end

    logic [N-1:0]               rawIn;
    logic [N-1:0]               cleanVec;
    sdr_pkg::sdr_pins_t         pins;
    logic [3:0]                 serClean;
    sdr_pkg::sdr_mode_t         mode;
    sdr_pkg::sdr_mode_t         next_mode;
    logic                       bypassActive;
    logic                       rateOk;
    logic                       bitStrobe;
    logic                       midStrobe;
    logic                       recClk;
    logic                       selBit;
    logic                       bypassBit;
    logic                       retimedBit;
    logic                       dataBit;
    logic                       muteAll;
    logic                       muteSec;
    logic [`SDR_CTRL_W-1:0]     ctrl;
    logic [`SDR_INT_W-1:0]      intStatus;
    logic [`SDR_INT_W-1:0]      intMask;
    logic [`SDR_INT_W-1:0]      evt;
    logic [`SDR_INT_W-1:0]      w1c;
    logic                       lockPrev;
    logic                       addrOk;
    logic                       wrPend;
    logic [`SDR_DEC_W-1:0]      wrAddr;
    logic [31:0]                statusWord;
    logic [31:0]                rdMux;

    // pins in sync order: select, clock select, bypass, silence, then serial data
    assign rawIn = {serialInputs, outputSilence_n, bypassForce,
                    clockOutSelect, inputSelectBit1, inputSelectBit0};

    // three stage pin synchroniser; a change counts once stages two and three agree
    for (genvar gi = 0; gi < N; gi++) begin : g_sync
        logic s1;
        logic s2;
        logic s3;
        logic q;
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                s1 <= SYNC_RST[gi];
                s2 <= SYNC_RST[gi];
                s3 <= SYNC_RST[gi];
                q  <= SYNC_RST[gi];
            end else begin
                s1 <= rawIn[gi];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    q <= s3;
                end
            end
        end
        assign cleanVec[gi] = q;
    end

    // reset values mirror the pad pulls: selects low, silence high
    assign pins     = sdr_pkg::sdr_pins_t'(cleanVec[`SDR_PIN_N-1:0]);
    assign serClean = cleanVec[N-1:`SDR_PIN_N];

    // harmonics and odd rates fall outside the retime set
    assign rateOk = sdr_pkg::sdr_rate_ok(detectedRate);

    // path mode choice; force wins over everything, lock needs data and a good rate
    always_comb begin
        if (pins.bypassForce || ctrl[`SDR_CTRL_BYPASS]) begin
            next_mode = sdr_pkg::MODE_FORCED;
        end else if (cdrLocked && signalPresent && rateOk) begin
            next_mode = sdr_pkg::MODE_RETIME;
        end else begin
            next_mode = sdr_pkg::MODE_AUTO;
        end
    end

    // mode register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= sdr_pkg::MODE_AUTO;
        end else begin
            mode <= next_mode;
        end
    end

    // bypass and lock follow the mode; the spare code is treated as bypass
    always_comb begin
        unique case (mode)
            sdr_pkg::MODE_AUTO: begin
                bypassActive = 1'h1;
            end
            sdr_pkg::MODE_RETIME: begin
                bypassActive = 1'h0;
            end
            sdr_pkg::MODE_FORCED: begin
                bypassActive = 1'h1;
            end
            default: begin
                bypassActive = 1'h1;
            end
        endcase
    end

    assign lockIndicator = (mode == sdr_pkg::MODE_RETIME);

    // bit timing for retime and recovered clock
    sdr_bit_timer #(
        .DIV       (BIT_DIV)
    ) u_timer (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .bitStrobe (bitStrobe),
        .midStrobe (midStrobe),
        .recClk    (recClk)
    );

    // only the selected input reaches either path
    assign selBit = serClean[pins.inputSelect];

    // bypass copies every cycle, retime samples on the bit boundary
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bypassBit  <= 1'h0;
            retimedBit <= 1'h0;
        end else begin
            bypassBit <= selBit;
            if (bitStrobe) begin
                retimedBit <= selBit;
            end
        end
    end

    assign dataBit = bypassActive ? bypassBit : retimedBit;

    // mute terms; software mute adds to the pin, never overrides it
    assign muteAll = !pins.silenceN || ctrl[`SDR_CTRL_MUTE];
    assign muteSec = muteAll || (pins.clockSelect && bypassActive);

    // primary output pair, static when muted
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            primarySerialOutput <= MUTED;
        end else if (muteAll) begin
            primarySerialOutput <= MUTED;
        end else begin
            primarySerialOutput <= '{p: dataBit, n: !dataBit};
        end
    end

    // secondary output pair: clock or second data copy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            secondarySerialOutput <= MUTED;
        end else if (muteSec) begin
            secondarySerialOutput <= MUTED;
        end else if (pins.clockSelect) begin
            secondarySerialOutput <= '{p: recClk, n: !recClk};
        end else begin
            secondarySerialOutput <= '{p: dataBit, n: !dataBit};
        end
    end

    // events: lock edges and an unsupported rate seen on the wire
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lockPrev <= 1'h0;
        end else begin
            lockPrev <= lockIndicator;
        end
    end

    assign evt[`SDR_INT_LOCK_UP] = lockIndicator && !lockPrev;
    assign evt[`SDR_INT_LOCK_DN] = !lockIndicator && lockPrev;
    assign evt[`SDR_INT_UNSUP]   = (detectedRate == sdr_pkg::RATE_UNSUP) ||
                                   (detectedRate == sdr_pkg::RATE_HARMONIC);

    // ahb address phase: single word transfers only
    assign addrOk    = hsel && hready && (htrans == `SDR_HTRANS_NSEQ) && (hsize == `SDR_HSIZE_WORD);
    assign hreadyout = 1'h1; // zero wait states
    assign hresp     = `SDR_HRESP_OKAY;

    // capture a write for its data phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPend <= 1'h0;
            wrAddr <= '0;
        end else begin
            wrPend <= addrOk && hwrite;
            if (addrOk && hwrite) begin
                wrAddr <= haddr[`SDR_DEC_W-1:0];
            end
        end
    end

    // one-to-clear strobe for the interrupt status register
    assign w1c = (wrPend && (wrAddr == `SDR_OFS_INT_STAT)) ? hwdata[`SDR_INT_W-1:0] : '0;

    // control and mask registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl    <= `SDR_CTRL_RST;
            intMask <= `SDR_INT_RST;
        end else if (wrPend) begin
            if (wrAddr == `SDR_OFS_CTRL) begin
                ctrl <= hwdata[`SDR_CTRL_W-1:0];
            end
            if (wrAddr == `SDR_OFS_INT_MASK) begin
                intMask <= hwdata[`SDR_INT_W-1:0];
            end
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            intStatus <= `SDR_INT_RST;
        end else begin
            intStatus <= (intStatus & ~w1c) | evt;
        end
    end

    assign irq = |(intStatus & intMask);

    // live status word
    assign statusWord = {{`SDR_STAT_PAD{1'h0}}, detectedRate, pins.inputSelect,
                         muteAll, pins.clockSelect, bypassActive, lockIndicator};

    // read mux; unmapped offsets read zero
    always_comb begin
        unique case (haddr[`SDR_DEC_W-1:0])
            `SDR_OFS_CTRL:     rdMux = 32'(ctrl);
            `SDR_OFS_STATUS:   rdMux = statusWord;
            `SDR_OFS_INT_STAT: rdMux = 32'(intStatus);
            `SDR_OFS_INT_MASK: rdMux = 32'(intMask);
            default:           rdMux = 32'h0;
        endcase
    end

    // read data registered in the address phase, valid through the data phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
        end else if (addrOk && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_clk_route;
        $past(pins.clockSelect && !muteSec) |-> secondarySerialOutput.p == $past(recClk);
    endproperty
    a_clk_route: assert property (p_clk_route) else $error("secondary not carrying clock");

    property p_data_route;
        $past(!pins.clockSelect && !muteSec) |-> secondarySerialOutput == primarySerialOutput;
    endproperty
    a_data_route: assert property (p_data_route) else $error("secondary not carrying data");

    property p_default_low;
        $past(!rst_n) |-> !pins.clockSelect && pins.inputSelect == 2'h0 && pins.silenceN;
    endproperty
    a_default_low: assert property (p_default_low) else $error("control defaults wrong");

    property p_mute_all;
        $past(!pins.silenceN) |-> primarySerialOutput == MUTED && secondarySerialOutput == MUTED;
    endproperty
    a_mute_all: assert property (p_mute_all) else $error("outputs not muted");

    property p_bypass_clk_mute;
        $past(pins.clockSelect && bypassActive) |-> secondarySerialOutput.p != secondarySerialOutput.n
            && secondarySerialOutput == MUTED;
    endproperty
    a_bypass_clk_mute: assert property (p_bypass_clk_mute) else $error("clock not muted in bypass");

    property p_mute_static;
        $past(muteAll) && muteAll |=> $stable(primarySerialOutput) && primarySerialOutput.p != primarySerialOutput.n;
    endproperty
    a_mute_static: assert property (p_mute_static) else $error("muted pair toggles");

    property p_lock_rate;
        lockIndicator |-> sdr_pkg::sdr_rate_ok($past(detectedRate));
    endproperty
    a_lock_rate: assert property (p_lock_rate) else $error("locked on unsupported rate");

    property p_unsup_bypass;
        $past(detectedRate == sdr_pkg::RATE_UNSUP) |-> !lockIndicator && bypassActive;
    endproperty
    a_unsup_bypass: assert property (p_unsup_bypass) else $error("unsupported rate not bypassed");

    property p_sel_forward;
        pins.inputSelect == 2'h3 |=> bypassBit == $past(serClean[3]);
    endproperty
    a_sel_forward: assert property (p_sel_forward) else $error("wrong input forwarded");

    property p_force_bypass;
        $past(pins.bypassForce) |-> !lockIndicator && bypassActive && dataBit == bypassBit;
    endproperty
    a_force_bypass: assert property (p_force_bypass) else $error("force bypass ignored");

    property p_lock_cause;
        lockIndicator |-> $past(cdrLocked && signalPresent && !pins.bypassForce);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without cause");

    property p_sync_silence;
        $changed(pins.silenceN) |-> pins.silenceN == $past(outputSilence_n, 4);
    endproperty
    a_sync_silence: assert property (p_sync_silence) else $error("silence pin not synchronised");

    c_retime: cover property (mode == sdr_pkg::MODE_RETIME ##1 lockIndicator);
    c_forced: cover property (mode == sdr_pkg::MODE_FORCED);
    c_clock_out: cover property (pins.clockSelect && !muteSec ##1 secondarySerialOutput.p);
    c_irq: cover property (irq);

endmodule

// [tb/sdr_cdr_model.sv]
// upstream model: equalized serial inputs and clock recovery status
`timescale 1ns/100ps
module sdr_cdr_model #(
    parameter int LOCK_WAIT = 3
) (
    input  wire logic          ref_clk,
    input  wire logic          present,
    input  sdr_pkg::sdr_rate_t rate,
    input  wire logic [3:0]    pat,
    output logic [3:0]         serialInputs,
    output logic               cdrLocked,
    output logic               signalPresent,
    output sdr_pkg::sdr_rate_t detectedRate
);
    int                 cnt = 0;
    sdr_pkg::sdr_rate_t lastRate = sdr_pkg::RATE_NONE;
    logic               wander = 1'h0;

    // loop re-acquires after each rate change; raw lock ignores the rate class,
    // so a harmonic lock must be refused by the block itself
    always @(posedge ref_clk) begin
        serialInputs  <= present ? pat : {4{wander}}; // no signal: lines wander
        wander        <= ~wander;
        signalPresent <= present;
        detectedRate  <= present ? rate : sdr_pkg::RATE_NONE;
        lastRate      <= rate;
        cnt           <= (!present || rate != lastRate) ? 0 : (cnt < LOCK_WAIT ? cnt + 1 : cnt);
        cdrLocked     <= present && cnt == LOCK_WAIT && rate == lastRate;
    end
endmodule

// [tb/tb.sv]
// self-checking testbench for the reclocker output control block
`timescale 1ns/100ps
`include "sdr_cfg.svh"
module tb;
    logic               ref_clk = 1'h0;
    logic               rst_n = 1'h0;
    logic [1:0]         sel = 2'h0;
    logic               clkSel = 1'h0;
    logic               silenceN = 1'h1;
    logic               byp = 1'h0;
    logic               present = 1'h0;
    sdr_pkg::sdr_rate_t rate = sdr_pkg::RATE_270;
    logic [3:0]         pat = 4'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'h0;
    logic [31:0]        haddr = 32'h0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        rd;
    logic [3:0]         serialInputs;
    logic               cdrLocked;
    logic               signalPresent;
    sdr_pkg::sdr_rate_t detectedRate;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic               lockIndicator;
    logic               irq;
    sdr_pkg::sdr_diff_t pri;
    sdr_pkg::sdr_diff_t sec;
    int                 errTotal = 0;
    int                 nCompared = 0;

    always #10 ref_clk = ~ref_clk;

    // single slave, so its hreadyout is the bus hready
    sdr_output_control #(.BIT_DIV(4)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .serialInputs(serialInputs),
        .inputSelectBit0(sel[0]), .inputSelectBit1(sel[1]), .clockOutSelect(clkSel),
        .outputSilence_n(silenceN), .bypassForce(byp), .cdrLocked(cdrLocked),
        .signalPresent(signalPresent), .detectedRate(detectedRate), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .primarySerialOutput(pri), .secondarySerialOutput(sec),
        .lockIndicator(lockIndicator), .irq(irq)
    );

    sdr_cdr_model #(.LOCK_WAIT(3)) model (
        .ref_clk(ref_clk), .present(present), .rate(rate), .pat(pat),
        .serialInputs(serialInputs), .cdrLocked(cdrLocked),
        .signalPresent(signalPresent), .detectedRate(detectedRate)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic go();
        @(posedge ref_clk);
    endtask

    // pins need four edges to sync, then mode and output registers; margin for relock
    task automatic settle();
        repeat (12) @(negedge ref_clk);
    endtask

    // one single word transfer; read data taken at the data phase edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= `SDR_HTRANS_NSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic tReset();
        repeat (3) @(negedge ref_clk);
        chk(pri, 2'h1);
        chk(sec, 2'h1);
        chk(lockIndicator, 1'h0);
        chk(irq, 1'h0);
    endtask

    // forced bypass passes only the selected input, lock held low
    task automatic tSelect();
        for (int i = 0; i < 4; i++) begin
            go();
            byp <= 1'h1;
            sel <= i[1:0];
            pat <= 4'h1 << i;
            settle();
            chk(pri, 2'h2);
            chk(sec, 2'h2);
            chk(lockIndicator, 1'h0);
            go();
            pat <= ~(4'h1 << i);
            settle();
            chk(pri, 2'h1);
        end
    endtask

    // only the five video rates lock; unsupported and harmonic stay bypassed
    task automatic tRates();
        for (int r = 1; r < 8; r++) begin
            go();
            byp <= 1'h0;
            pat <= 4'hf;
            rate <= sdr_pkg::sdr_rate_t'(r);
            settle();
            chk(lockIndicator, r < 6);
            chk(pri, 2'h2);
        end
    endtask

    // clock mode: half duty at bit rate, muted whenever bypassed
    task automatic tClock();
        int ones;
        go();
        rate <= sdr_pkg::RATE_2970;
        clkSel <= 1'h1;
        settle();
        ones = 0;
        repeat (8) begin
            @(negedge ref_clk);
            ones += sec.p;
            chk(sec.n ^ sec.p, 1'h1);
        end
        chk(ones, 4);
        go();
        rate <= sdr_pkg::RATE_UNSUP;
        settle();
        chk(sec, 2'h1);
        chk(pri, 2'h2);
        go();
        rate <= sdr_pkg::RATE_270;
        byp <= 1'h1;
        settle();
        chk(sec, 2'h1);
        go();
        byp <= 1'h0;
        clkSel <= 1'h0;
    endtask

    task automatic tMute();
        go();
        silenceN <= 1'h0;
        settle();
        repeat (4) begin
            @(negedge ref_clk);
            chk(pri, 2'h1);
            chk(sec, 2'h1);
        end
        go();
        silenceN <= 1'h1;
        settle();
        chk(pri, 2'h2);
    endtask

    // soft mute, unmapped read, status, rate interrupt masked and cleared
    task automatic tRegs();
        go();
        ahb(1'h1, `SDR_OFS_CTRL, 32'h1);
        ahb(1'h0, `SDR_OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        chk(hresp, `SDR_HRESP_OKAY);
        chk(hreadyout, 1'h1);
        settle();
        chk(pri, 2'h1);
        go();
        ahb(1'h1, `SDR_OFS_CTRL, 32'h2);
        settle();
        chk(lockIndicator, 1'h0);
        chk(pri, 2'h2);
        go();
        ahb(1'h1, `SDR_OFS_CTRL, 32'h0);
        ahb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        ahb(1'h0, `SDR_OFS_STATUS, 32'h0);
        chk(rd[0], 1'h1);
        // drop events left by earlier scenarios so the rate event is seen fresh
        ahb(1'h1, `SDR_OFS_INT_STAT, 32'h7);
        ahb(1'h1, `SDR_OFS_INT_MASK, 32'h1 << `SDR_INT_UNSUP);
        @(negedge ref_clk);
        chk(irq, 1'h0);
        go();
        rate <= sdr_pkg::RATE_UNSUP;
        settle();
        chk(irq, 1'h1);
        go();
        ahb(1'h1, `SDR_OFS_INT_MASK, 32'h0);
        rate <= sdr_pkg::RATE_270;
        settle();
        chk(irq, 1'h0);
        go();
        ahb(1'h1, `SDR_OFS_INT_STAT, 32'h7);
        ahb(1'h1, `SDR_OFS_INT_MASK, 32'h7);
        ahb(1'h0, `SDR_OFS_INT_STAT, 32'h0);
        chk(rd[2:0], 3'h0);
        chk(irq, 1'h0);
    endtask

    task automatic finalReport();
        $display("compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // whole run is a few hundred cycles; this only cuts a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        errTotal++;
        $display("CHECK FAILED at %0t ns: run timed out", $time);
        finalReport();
    end

    initial begin
        tReset();
        repeat (7) @(posedge ref_clk);
        rst_n <= 1'h1;
        present <= 1'h1;
        tSelect();
        tRates();
        tClock();
        tMute();
        tRegs();
        finalReport();
    end
endmodule
